/* File: hw/psm_pkg.sv */
// package: constants and carrier types for the pwm sync master/slave shell
package psm_pkg;
  localparam int CNT_W = 16;
  localparam int N_CAP = 3;
  localparam int N_MAT = 6;
  localparam int DLY_W = 16;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [DLY_W-1:0] DLY_RST = 16'h0000;

  typedef struct packed {
    logic sync;
    logic trans;
  } psm_sync_t;

  typedef struct packed {
    logic [CNT_W-1:0] period;
    logic [N_MAT-1:0][CNT_W-1:0] rise;
    logic [N_MAT-1:0][CNT_W-1:0] fall;
  } psm_shadow_t;

  typedef enum logic [2:0] {
    DL_IDLE = 3'b001,
    DL_WAIT = 3'b010,
    DL_FIRE = 3'b100
  } psm_dly_st_t;
endpackage

/* File: hw/psm_pwm_module.sv */
// module: one pwm module with sync master/slave, capture, match and trap
module psm_pwm_module
  import psm_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic slave_mode,
  input wire logic run,
  input wire logic [psm_pkg::CNT_W-1:0] prescale,
  input wire logic [psm_pkg::DLY_W-1:0] sync_delay,
  input wire psm_pkg::psm_shadow_t sw_regs,
  input wire logic sw_update,
  input wire logic [psm_pkg::N_MAT-1:0] trap_level,
  input wire logic trap_irq_en,
  input wire logic trap_clear,
  input wire psm_pkg::psm_sync_t sync_in,
  input wire logic [psm_pkg::N_CAP-1:0] capture_input_pin,
  input wire logic protective_stop_input,
  output psm_pkg::psm_sync_t sync_out,
  output logic [psm_pkg::N_MAT-1:0] match_output_pin,
  output logic [psm_pkg::N_CAP-1:0][psm_pkg::CNT_W-1:0] capture_val,
  output logic [psm_pkg::N_CAP-1:0] capture_evt,
  output logic trap_active,
  output logic trap_irq,
  output logic [psm_pkg::CNT_W-1:0] pwm_count
);
  import psm_pkg::*;
  // clk is this module's branch clock; gating it upstream stops the module
  logic [CNT_W-1:0] pre_ff;
  logic [CNT_W-1:0] cnt_ff;
  psm_shadow_t shadow_ff;
  logic pend_ff;
  logic sync_in_d_ff;
  logic trans_in_d_ff;
  logic [N_CAP-1:0] cap_d_ff;
  logic trap_ff;
  logic trap_irq_ff;
  logic [N_MAT-1:0] mat_ff;
  logic [N_CAP-1:0][CNT_W-1:0] cap_ff;
  logic [N_CAP-1:0] cap_evt_ff;
  logic tick;
  logic wrap;
  logic restart;
  logic copied;

  assign tick = run && (pre_ff == prescale);
  assign wrap = tick && (cnt_ff == shadow_ff.period);
  // slave restart follows the input pulse by one cycle
  // own period wrap restarts a slave too, so a missed sync cannot run it away
  assign restart = wrap || sync_in_d_ff;
  assign copied = slave_mode ? trans_in_d_ff : (wrap && pend_ff);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sync_in_d_ff <= 1'b0;
      trans_in_d_ff <= 1'b0;
    end else begin
      sync_in_d_ff <= slave_mode && sync_in.sync;
      trans_in_d_ff <= slave_mode && sync_in.sync && sync_in.trans;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pre_ff <= CNT_RST;
    end else if (restart || tick || !run) begin
      pre_ff <= CNT_RST;
    end else begin
      pre_ff <= pre_ff + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_ff <= CNT_RST;
    end else if (restart) begin
      cnt_ff <= CNT_RST;
    end else if (tick) begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end

  // software update arms a copy in master mode, the transfer flag alone in slave mode; the copy only lands at a restart
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pend_ff <= 1'b0;
      shadow_ff <= '0;
    end else begin
      if (restart && copied) begin
        shadow_ff <= sw_regs;
      end
      if (sw_update) begin
        pend_ff <= 1'b1;
      end else if (restart && copied) begin
        pend_ff <= 1'b0;
      end
    end
  end

  psm_sync_delay u_dly (
    .clk(clk),
    .rstn(rstn),
    .restart(restart && !slave_mode),
    .copied(copied),
    .delay(sync_delay),
    .sync_out(sync_out)
  );

  // trap set beats the clear so a stop during clear is not lost
  always_ff @(posedge clk) begin
    if (!rstn) begin
      trap_ff <= 1'b0;
      trap_irq_ff <= 1'b0;
    end else begin
      if (protective_stop_input) begin
        trap_ff <= 1'b1;
      end else if (trap_clear) begin
        trap_ff <= 1'b0;
      end
      if (protective_stop_input && !trap_ff && trap_irq_en) begin
        trap_irq_ff <= 1'b1;
      end else if (trap_clear) begin
        trap_irq_ff <= 1'b0;
      end
    end
  end

  genvar i;
  generate
    for (i = 0; i < N_MAT; i++) begin : g_mat
      always_ff @(posedge clk) begin
        if (!rstn) begin
          mat_ff[i] <= 1'b0;
        end else if (trap_ff || protective_stop_input) begin
          mat_ff[i] <= trap_level[i];
        end else if (restart) begin
          mat_ff[i] <= 1'b0;
        end else if (tick && cnt_ff == shadow_ff.rise[i]) begin
          mat_ff[i] <= 1'b1;
        end else if (tick && cnt_ff == shadow_ff.fall[i]) begin
          mat_ff[i] <= 1'b0;
        end
      end
    end
    for (i = 0; i < N_CAP; i++) begin : g_cap
      always_ff @(posedge clk) begin
        if (!rstn) begin
          cap_d_ff[i] <= 1'b0;
          cap_ff[i] <= CNT_RST;
          cap_evt_ff[i] <= 1'b0;
        end else begin
          cap_d_ff[i] <= capture_input_pin[i];
          cap_evt_ff[i] <= capture_input_pin[i] && !cap_d_ff[i];
          if (capture_input_pin[i] && !cap_d_ff[i]) begin
            cap_ff[i] <= cnt_ff;
          end
        end
      end
    end
  endgenerate

  assign match_output_pin = mat_ff;
  assign capture_val = cap_ff;
  assign capture_evt = cap_evt_ff;
  assign trap_active = trap_ff;
  assign trap_irq = trap_irq_ff;
  assign pwm_count = cnt_ff;

  sequence slave_sync_s;
    slave_mode && sync_in.sync;
  endsequence
  slave_restart_a: assert property (@(posedge clk) disable iff (!rstn)
    slave_sync_s ##1 slave_mode |=> cnt_ff == CNT_RST && pre_ff == CNT_RST)
    else $error("slave counters not restarted after sync input");
  master_pulse_a: assert property (@(posedge clk) disable iff (!rstn)
    (!slave_mode && sync_out.sync) |=> !sync_out.sync || restart)
    else $error("sync output longer than one cycle");
  trap_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    protective_stop_input |=> match_output_pin == $past(trap_level) && trap_active)
    else $error("outputs not held at trap level");
  capture_store_a: assert property (@(posedge clk) disable iff (!rstn)
    (capture_input_pin[0] && !cap_d_ff[0]) |=> capture_val[0] == $past(cnt_ff))
    else $error("capture did not store the counter");
  shadow_load_a: assert property (@(posedge clk) disable iff (!rstn)
    (slave_mode && sync_in.sync && !sync_in.trans) ##1 slave_mode |=>
      shadow_ff == $past(shadow_ff))
    else $error("slave shadow loaded without transfer enable");
endmodule

/* File: hw/psm_sync_delay.sv */
// module: programmable delay of the master's sync and transfer pulses
module psm_sync_delay
  import psm_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic restart,
  input wire logic copied,
  input wire logic [psm_pkg::DLY_W-1:0] delay,
  output psm_pkg::psm_sync_t sync_out
);
  import psm_pkg::*;
  psm_dly_st_t st_ff;
  logic [DLY_W-1:0] cnt_ff;
  logic trans_ff;
  logic zero;
  assign zero = (delay == DLY_RST);

  // a restart during a pending delay re-arms it; only the latest period matters
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_ff <= DL_IDLE;
      cnt_ff <= DLY_RST;
      trans_ff <= 1'b0;
    end else if (restart && !zero) begin
      st_ff <= DL_WAIT;
      cnt_ff <= delay - 16'h0001;
      trans_ff <= copied;
    end else begin
      unique case (st_ff)
        DL_IDLE: st_ff <= DL_IDLE;
        DL_WAIT: begin
          if (cnt_ff == DLY_RST) begin
            st_ff <= DL_FIRE;
          end else begin
            cnt_ff <= cnt_ff - 16'h0001;
          end
        end
        DL_FIRE: st_ff <= DL_IDLE;
        default: st_ff <= DL_IDLE;
      endcase
    end
  end

  always_comb begin
    if (restart && zero) begin
      sync_out.sync = 1'b1;
      sync_out.trans = copied;
    end else begin
      sync_out.sync = (st_ff == DL_FIRE);
      sync_out.trans = (st_ff == DL_FIRE) && trans_ff;
    end
  end

  sequence restart_delayed_s;
    restart && !zero;
  endsequence
  sync_delay_a: assert property (@(posedge clk) disable iff (!rstn)
    (restart && !zero && delay == 16'h0001) ##1 !restart |-> ##1 sync_out.sync)
    else $error("delayed sync pulse not emitted on time");
  trans_pair_a: assert property (@(posedge clk) disable iff (!rstn)
    sync_out.trans |-> sync_out.sync)
    else $error("transfer pulse without sync pulse");
  zero_delay_a: assert property (@(posedge clk) disable iff (!rstn)
    (restart && zero) |-> sync_out.sync)
    else $error("zero delay sync not in restart cycle");
  no_early_a: assert property (@(posedge clk) disable iff (!rstn)
    restart_delayed_s |=> !sync_out.sync || restart)
    else $error("delayed sync came too early");
endmodule

/* File: tb/psm_partner.sv */
// neighbour module model: upstream master driving the sync inputs
module psm_partner
  import psm_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic fire,
  input wire logic fire_trans,
  output psm_pkg::psm_sync_t sync_out
);
  import psm_pkg::*;
  // sync repeats fire one cycle later, as long as fire is held; trans only ever rides on it
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sync_out <= '0;
    end else begin
      sync_out.sync <= fire;
      sync_out.trans <= fire & fire_trans;
    end
  end
endmodule

/* File: tb/pwm_sync_master_slave_test.sv */
// self-checking bench for one pwm module, master and slave roles
module pwm_sync_master_slave_test;
  timeunit 1ns;
  timeprecision 100ps;
  import psm_pkg::*;
  logic clk = 0, rstn = 0, slave_mode = 0, run = 0, sw_update = 0;
  logic trap_irq_en = 0, trap_clear = 0, stop = 0, fire = 0, fire_trans = 0;
  logic [CNT_W-1:0] prescale = '0;
  logic [DLY_W-1:0] sync_delay = '0;
  psm_shadow_t sw_regs = '0;
  logic [N_MAT-1:0] trap_level = '0;
  logic [N_CAP-1:0] cap = '0;
  psm_sync_t sync_in, sync_out;
  logic [N_MAT-1:0] mat;
  logic [N_CAP-1:0][CNT_W-1:0] capture_val;
  logic [N_CAP-1:0] capture_evt;
  logic trap_active, trap_irq;
  logic [CNT_W-1:0] pwm_count;
  int fail_count = 0, comparisons = 0, cycles = 0;
  always #2.5 clk = ~clk;
  psm_partner psm_partner_i (.clk(clk), .rstn(rstn), .fire(fire), .fire_trans(fire_trans),
    .sync_out(sync_in));
  psm_pwm_module psm_pwm_module_i (.clk(clk), .rstn(rstn), .slave_mode(slave_mode), .run(run),
    .prescale(prescale), .sync_delay(sync_delay), .sw_regs(sw_regs), .sw_update(sw_update),
    .trap_level(trap_level), .trap_irq_en(trap_irq_en), .trap_clear(trap_clear),
    .sync_in(sync_in), .capture_input_pin(cap), .protective_stop_input(stop),
    .sync_out(sync_out), .match_output_pin(mat), .capture_val(capture_val),
    .capture_evt(capture_evt), .trap_active(trap_active), .trap_irq(trap_irq),
    .pwm_count(pwm_count));
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    if (fail_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      finish_test();
    end
  end
  // master: pulse spacing, width, delay offset and single transfer flag
  task automatic run_master(input int d);
    int top, last, n, ntr, nhi;
    nhi = 0;
    top = -100;
    last = -100;
    n = 0;
    ntr = 0;
    slave_mode = 0;
    sync_delay = DLY_W'(d);
    sw_regs.period = 16'h0007;
    sw_regs.rise[0] = 16'h0002;
    sw_regs.fall[0] = 16'h0005;
    run = 1;
    sw_update = 1;
    tick();
    sw_update = 0;
    // sample first so the copy pulse right after the update is seen
    for (int c = 0; c < 60; c++) begin
      if (pwm_count === 16'h0007) top = c;
      if (c >= 20 && c < 52 && mat[0] === 1'b1) nhi++;
      chk("trans_with_sync", 0, 32'(sync_out.trans & ~sync_out.sync));
      if (sync_out.trans === 1'b1) ntr++;
      if (sync_out.sync === 1'b1) begin
        n++;
        chk("sync_width", 1, 32'(c - last > 1));
        if (n >= 3) chk("sync_spacing", 8, 32'(c - last));
        if (n >= 3) chk("sync_offset", d == 0 ? 0 : d + 1, 32'(c - top));
        last = c;
      end
      tick();
    end
    chk("trans_count", 1, 32'(ntr));
    chk("sync_seen", 1, 32'(n >= 6));
    chk("match_high", 12, 32'(nhi));
    run = 0;
    tick();
  endtask
  // slave: restart from sync input, new period from the transfer flag
  task automatic run_slave();
    slave_mode = 1;
    prescale = 16'h0003;
    sw_regs.period = 16'h0005;
    sw_update = 1;
    run = 1;
    tick();
    sw_update = 0;
    tick(5);
    fire = 1;
    fire_trans = 1;
    tick();
    fire = 0;
    fire_trans = 0;
    chk("sync_in_seen", 1, 32'(sync_in.sync));
    tick(2);
    chk("slave_restart", 0, 32'(pwm_count));
    tick(20);
    chk("slave_top", 5, 32'(pwm_count));
    tick(4);
    chk("slave_wrap", 0, 32'(pwm_count));
    chk("slave_no_sync", 0, 32'(sync_out));
    // sync without transfer: restart but keep the old period
    sw_regs.period = 16'h0003;
    fire = 1;
    tick();
    fire = 0;
    tick(2);
    chk("slave_resync", 0, 32'(pwm_count));
    tick(16);
    chk("slave_keep_shadow", 4, 32'(pwm_count));
    run = 0;
    prescale = '0;
  endtask
  // capture: freeze counter so the stored value is known
  task automatic run_capture();
    logic [CNT_W-1:0] held;
    tick(2);
    held = pwm_count;
    for (int i = 0; i < N_CAP; i++) begin
      cap[i] = 1;
      tick();
      chk("capture_evt", 1, 32'(capture_evt[i]));
      tick(2);
      chk("capture_val", 32'(held), 32'(capture_val[i]));
      chk("capture_evt_end", 0, 32'(capture_evt[i]));
      cap[i] = 0;
      tick(2);
    end
  endtask
  task automatic run_trap();
    trap_level = 6'h2A;
    trap_irq_en = 1;
    // stop and clear together: the stop must win
    stop = 1;
    trap_clear = 1;
    tick();
    trap_clear = 0;
    tick(2);
    chk("trap_active", 1, 32'(trap_active));
    chk("trap_levels", 32'h2A, 32'(mat));
    chk("trap_irq", 1, 32'(trap_irq));
    stop = 0;
    trap_clear = 1;
    tick();
    trap_clear = 0;
    tick(2);
    chk("trap_cleared", 0, 32'({trap_active, trap_irq}));
  endtask
  initial begin
    tick(6);
    rstn = 1;
    tick();
    run_master(0);
    run_master(3);
    run_master(1);
    run_slave();
    run_capture();
    run_trap();
    finish_test();
  end
endmodule
